// ===== common/lp_pkg.sv
// constants shared by both ends of the low-power control link
// assumes a single 20 MHz clock shared by host and converter end
package lp_pkg;
    localparam int CLK_NS = 50;
    // converter register map as seen over the link
    localparam logic [7:0] KEY_ADDR = 8'h05;
    localparam logic [7:0] KEY_VALUE = 8'h69;
    localparam logic [7:0] PWRCTL_ADDR = 8'h04;
    localparam int LS_EN_BIT = 0;
    localparam int DS_REQ_BIT = 1;
    localparam logic [7:0] PWRCTL_RESET = 8'h00;
    // times in ns and their cycle counts, least times rounded up
    localparam int CONV_NS = 1000;
    localparam int LS_WAKE_NS = 2000;
    localparam int PWRUP_NS = 50000;
    localparam int CONV_CYCLES = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int LS_WAKE_CYCLES = (LS_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PWRUP_CYCLES = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
    // host apb register offsets
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam int CFG_LS_EN_BIT = 0;
    localparam int CFG_HOLD_BIT = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_CONVERT = 3'h1,
        OP_CONFIG_LS = 3'h2,
        OP_DS_ENTER = 3'h3,
        OP_DS_EXIT = 3'h4,
        OP_WAKE = 3'h5
    } op_t;
endpackage

// ===== common/lp_link_if.sv
// link between host controller and converter low-power control
// assumes both ends run on the same pclk
`timescale 1ns/1ps
`default_nettype none
interface lp_link_if;
    logic convert_start_select;
    logic ready_indicator;
    logic reg_wr_strobe;
    logic [7:0] reg_wr_addr;
    logic [7:0] reg_wr_data;
    modport device (
        input convert_start_select,
        input reg_wr_strobe,
        input reg_wr_addr,
        input reg_wr_data,
        output ready_indicator
    );
    modport host (
        output convert_start_select,
        output reg_wr_strobe,
        output reg_wr_addr,
        output reg_wr_data,
        input ready_indicator
    );
endinterface
`default_nettype wire

// ===== hw/adc_lp_device.sv
// converter-side low-power sequencer: normal, light sleep, deep sleep
// assumes the host drives the link synchronously to pclk
`timescale 1ns/1ps
`default_nettype none
module adc_lp_device #(
    parameter int CONV_CYCLES = lp_pkg::CONV_CYCLES,
    parameter int WAKE_CYCLES = lp_pkg::LS_WAKE_CYCLES,
    parameter int PWRUP_CYCLES = lp_pkg::PWRUP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    lp_link_if.device link,
    output logic analog_power_on,
    output logic blocks_reduced_power,
    output logic in_light_sleep,
    output logic in_deep_sleep,
    output logic conversion_done,
    output logic light_sleep_enable,
    output logic deep_sleep_request
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CONV,
        ST_LIGHT,
        ST_WAKE,
        ST_DEEP,
        ST_POWERUP
    } dev_state_t;

    dev_state_t state_r;
    dev_state_t state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic cs_q_r;
    logic cs_rise;
    logic cs_fall;
    logic unlock_r;
    logic ls_en_r;
    logic ds_req_r;
    logic ready_r;
    logic done_r;
    logic key_wr;
    logic ctl_wr;

    function automatic logic [15:0] load_count(input int cycles);
        // a count of zero still lasts one cycle
        if (cycles < 2) begin
            return 16'h0000;
        end
        return 16'(cycles - 1);
    endfunction

    assign cs_rise = link.convert_start_select & ~cs_q_r;
    assign cs_fall = ~link.convert_start_select & cs_q_r;
    assign key_wr = link.reg_wr_strobe && link.reg_wr_addr == lp_pkg::KEY_ADDR
                    && link.reg_wr_data == lp_pkg::KEY_VALUE;
    assign ctl_wr = link.reg_wr_strobe && link.reg_wr_addr == lp_pkg::PWRCTL_ADDR;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_q_r <= 1'b0;
        end else begin
            cs_q_r <= link.convert_start_select;
        end
    end

    // the key arms exactly one following write; any other write disarms it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_r <= 1'b0;
        end else if (link.reg_wr_strobe) begin
            unlock_r <= key_wr;
        end
    end

    // control bits survive deep sleep since only reset or an unlocked write touches them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_en_r <= lp_pkg::PWRCTL_RESET[lp_pkg::LS_EN_BIT];
            ds_req_r <= lp_pkg::PWRCTL_RESET[lp_pkg::DS_REQ_BIT];
        end else if (ctl_wr && unlock_r) begin
            ls_en_r <= link.reg_wr_data[lp_pkg::LS_EN_BIT];
            ds_req_r <= link.reg_wr_data[lp_pkg::DS_REQ_BIT];
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : 16'h0000;
        unique case (state_r)
            ST_IDLE: begin
                if (cs_rise && ds_req_r) begin
                    state_nxt = ST_DEEP;
                end else if (cs_rise) begin
                    state_nxt = ST_CONV;
                    cnt_nxt = load_count(CONV_CYCLES);
                end
            end
            ST_CONV: begin
                if (cnt_r == 16'h0000) begin
                    if (ls_en_r && link.convert_start_select) begin
                        state_nxt = ST_LIGHT;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_LIGHT: begin
                // stays while the pin is held high
                if (cs_fall) begin
                    state_nxt = ST_WAKE;
                    // the fall is seen one edge late, so one cycle of the wake time is already gone
                    cnt_nxt = load_count(WAKE_CYCLES - 1);
                end
            end
            ST_WAKE: begin
                // a rising edge here breaks the host's wait and is dropped
                if (cnt_r == 16'h0000) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DEEP: begin
                if (!ds_req_r) begin
                    state_nxt = ST_POWERUP;
                    cnt_nxt = load_count(PWRUP_CYCLES);
                end
            end
            ST_POWERUP: begin
                if (cnt_r == 16'h0000) begin
                    state_nxt = ST_IDLE;
                end
            end
            // unused codes fall back to idle
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ready is low only while a conversion is running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_r <= 1'b1;
        end else begin
            ready_r <= (state_nxt != ST_CONV);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == ST_CONV) && (state_nxt != ST_CONV);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_power_on <= 1'b1;
            blocks_reduced_power <= 1'b0;
            in_light_sleep <= 1'b0;
            in_deep_sleep <= 1'b0;
        end else begin
            // normal and powering-up states keep full power between conversions
            analog_power_on <= (state_nxt != ST_DEEP);
            blocks_reduced_power <= (state_nxt == ST_LIGHT);
            in_light_sleep <= (state_nxt == ST_LIGHT);
            in_deep_sleep <= (state_nxt == ST_DEEP);
        end
    end

    assign link.ready_indicator = ready_r;
    assign conversion_done = done_r;
    assign light_sleep_enable = ls_en_r;
    assign deep_sleep_request = ds_req_r;
endmodule
`default_nettype wire

// ===== hw/adc_lp_host.sv
// host controller: apb slave that sequences the converter link
// assumes shared pclk; software polls the status busy bit
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module adc_lp_host #(
    parameter int WAKE_CYCLES = lp_pkg::LS_WAKE_CYCLES,
    parameter int PWRUP_CYCLES = lp_pkg::PWRUP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    lp_link_if.host link
);
    typedef enum logic [2:0] {
        H_IDLE,
        H_KEY,
        H_CTL,
        H_RISE,
        H_BUSY,
        H_WAIT,
        H_DS_EDGE,
        H_DS_DROP
    } host_state_t;

    host_state_t state_r;
    lp_pkg::op_t op_r;
    logic [1:0] cfg_r;
    logic ls_sh_r;
    logic ds_sh_r;
    logic cs_r;
    logic conv_after_r;
    logic [15:0] cnt_r;
    logic wr_stb_r;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic apb_wr;
    logic mapped;
    logic cmd_go;
    logic [2:0] cmd_op;

    function automatic logic [15:0] load_count(input int cycles);
        if (cycles < 2) begin
            return 16'h0000;
        end
        return 16'(cycles - 1);
    endfunction

    assign mapped = paddr == lp_pkg::CFG_OFS || paddr == lp_pkg::CMD_OFS || paddr == lp_pkg::STATUS_OFS;
    assign apb_wr = psel && penable && pwrite && mapped;
    assign cmd_op = pwdata[2:0];
    assign cmd_go = apb_wr && paddr == lp_pkg::CMD_OFS && state_r == H_IDLE
                    && cmd_op != lp_pkg::OP_NONE && cmd_op <= lp_pkg::OP_WAKE;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == lp_pkg::CFG_OFS) begin
            prdata = {30'h0000_0000, cfg_r};
        end else if (paddr == lp_pkg::STATUS_OFS) begin
            prdata = {27'h000_0000, ds_sh_r, ls_sh_r, cs_r, link.ready_indicator, state_r != H_IDLE};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= lp_pkg::CFG_RESET;
        end else if (apb_wr && paddr == lp_pkg::CFG_OFS) begin
            cfg_r <= pwdata[1:0];
        end
    end

    // every control write is preceded by the key write, one cycle apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= H_IDLE;
            op_r <= lp_pkg::OP_NONE;
            cs_r <= 1'b0;
            conv_after_r <= 1'b0;
            cnt_r <= 16'h0000;
            wr_stb_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            ls_sh_r <= 1'b0;
            ds_sh_r <= 1'b0;
        end else begin
            wr_stb_r <= 1'b0;
            if (cnt_r != 16'h0000) begin
                cnt_r <= cnt_r - 16'h0001;
            end
            unique case (state_r)
                H_IDLE: begin
                    if (cmd_go) begin
                        op_r <= lp_pkg::op_t'(cmd_op);
                        if (cmd_op == lp_pkg::OP_CONVERT && cs_r) begin
                            cs_r <= 1'b0;
                            conv_after_r <= 1'b1;
                            cnt_r <= load_count(WAKE_CYCLES);
                            state_r <= H_WAIT;
                        end else if (cmd_op == lp_pkg::OP_CONVERT) begin
                            cs_r <= 1'b1;
                            state_r <= H_RISE;
                        end else if (cmd_op == lp_pkg::OP_WAKE) begin
                            cs_r <= 1'b0;
                            cnt_r <= load_count(WAKE_CYCLES);
                            state_r <= H_WAIT;
                        end else begin
                            wr_stb_r <= 1'b1;
                            wr_addr_r <= lp_pkg::KEY_ADDR;
                            wr_data_r <= lp_pkg::KEY_VALUE;
                            state_r <= H_KEY;
                        end
                    end
                end
                H_KEY: begin
                    wr_stb_r <= 1'b1;
                    wr_addr_r <= lp_pkg::PWRCTL_ADDR;
                    wr_data_r <= 8'h00;
                    if (op_r == lp_pkg::OP_CONFIG_LS) begin
                        wr_data_r[lp_pkg::LS_EN_BIT] <= cfg_r[lp_pkg::CFG_LS_EN_BIT];
                        wr_data_r[lp_pkg::DS_REQ_BIT] <= ds_sh_r;
                        ls_sh_r <= cfg_r[lp_pkg::CFG_LS_EN_BIT];
                    end else begin
                        wr_data_r[lp_pkg::LS_EN_BIT] <= ls_sh_r;
                        wr_data_r[lp_pkg::DS_REQ_BIT] <= (op_r == lp_pkg::OP_DS_ENTER);
                        ds_sh_r <= (op_r == lp_pkg::OP_DS_ENTER);
                    end
                    state_r <= H_CTL;
                end
                H_CTL: begin
                    if (op_r == lp_pkg::OP_DS_ENTER) begin
                        state_r <= H_DS_EDGE;
                    end else if (op_r == lp_pkg::OP_DS_EXIT) begin
                        cnt_r <= load_count(PWRUP_CYCLES);
                        state_r <= H_WAIT;
                    end else begin
                        state_r <= H_IDLE;
                    end
                end
                H_DS_EDGE: begin
                    cs_r <= 1'b1;
                    state_r <= H_DS_DROP;
                end
                H_DS_DROP: begin
                    cs_r <= 1'b0;
                    state_r <= H_IDLE;
                end
                H_RISE: begin
                    if (!link.ready_indicator) begin
                        // without hold the pin must already be low when the conversion ends
                        cs_r <= cfg_r[lp_pkg::CFG_HOLD_BIT];
                        state_r <= H_BUSY;
                    end
                end
                H_BUSY: begin
                    if (link.ready_indicator) begin
                        // holding the pin high lets the converter nap after this sample
                        cs_r <= cfg_r[lp_pkg::CFG_HOLD_BIT];
                        state_r <= H_IDLE;
                    end
                end
                H_WAIT: begin
                    if (cnt_r == 16'h0000) begin
                        conv_after_r <= 1'b0;
                        if (conv_after_r) begin
                            cs_r <= 1'b1;
                            state_r <= H_RISE;
                        end else begin
                            state_r <= H_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign link.convert_start_select = cs_r;
    assign link.reg_wr_strobe = wr_stb_r;
    assign link.reg_wr_addr = wr_addr_r;
    assign link.reg_wr_data = wr_data_r;
endmodule
`default_nettype wire

// ===== verification/adc_lp_monitor.sv
// concurrent checks on the host-to-converter link and converter state
// assumes one pclk domain; placed beside the link in the bench top
`timescale 1ns/1ps
`default_nettype none
module adc_lp_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic convert_start_select,
    input wire logic ready_indicator,
    input wire logic reg_wr_strobe,
    input wire logic [7:0] reg_wr_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic analog_power_on,
    input wire logic blocks_reduced_power,
    input wire logic in_light_sleep,
    input wire logic in_deep_sleep,
    input wire logic light_sleep_enable,
    input wire logic deep_sleep_request
);
    logic key_armed_r;
    logic ctrl_wr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // the key arms only the very next write, any other write disarms it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_armed_r <= 1'b0;
        end else if (reg_wr_strobe) begin
            key_armed_r <= (reg_wr_addr == lp_pkg::KEY_ADDR) && (reg_wr_data == lp_pkg::KEY_VALUE);
        end
    end
    assign ctrl_wr = reg_wr_strobe && (reg_wr_addr == lp_pkg::PWRCTL_ADDR) && key_armed_r;
    chk_power_follows_deep: assert property (analog_power_on == !in_deep_sleep)
        else $error("analog power disagrees with deep sleep state");
    chk_reduced_only_light: assert property (blocks_reduced_power == in_light_sleep)
        else $error("reduced power disagrees with light sleep state");
    chk_ready_in_deep: assert property (in_deep_sleep |-> ready_indicator)
        else $error("ready low in deep sleep");
    chk_ready_on_exit: assert property ($fell(deep_sleep_request) |-> ready_indicator [*3])
        else $error("ready not held high while leaving deep sleep");
    chk_light_entry_cause: assert property ($rose(in_light_sleep) |-> light_sleep_enable && convert_start_select)
        else $error("light sleep entered without enable and pin high");
    chk_light_stays: assert property (in_light_sleep && convert_start_select |=> in_light_sleep)
        else $error("light sleep left while pin high");
    chk_light_wake_edge: assert property (in_light_sleep && $fell(convert_start_select) |=> !in_light_sleep)
        else $error("falling pin did not end light sleep");
    chk_deep_entry_edge: assert property ($rose(convert_start_select) && deep_sleep_request && ready_indicator
        && !in_deep_sleep |=> in_deep_sleep)
        else $error("rising pin with deep request did not enter deep sleep");
    chk_ctrl_needs_key: assert property ($changed(light_sleep_enable) || $changed(deep_sleep_request)
        |-> $past(ctrl_wr))
        else $error("control bits changed without unlocked write");
    chk_ctrl_takes_data: assert property (ctrl_wr |=> {deep_sleep_request, light_sleep_enable}
        == $past(reg_wr_data[1:0]))
        else $error("control bits differ from unlocked write data");
    cover property ($rose(in_light_sleep));
    cover property ($rose(in_deep_sleep));
    cover property ($fell(deep_sleep_request));
    cover property (ctrl_wr);
endmodule
`default_nettype wire

// ===== verification/tb_adc_low_power_mode_control.sv
// self-checking bench: apb software driving host and converter over the link
// assumes shortened counts; a second converter end is fed bad key sequences
`timescale 1ns/1ps
`default_nettype none
module tb_adc_low_power_mode_control;
    localparam int CYC = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic analog_power_on, blocks_reduced_power, in_light_sleep, in_deep_sleep;
    logic light_sleep_enable, deep_sleep_request, b_ls_en, b_ds_req;
    logic conv_done;
    int done_seen = 0;
    int err_total = 0;
    int cmp_count = 0;
    lp_link_if link ();
    lp_link_if bad_link ();
    adc_lp_host #(.WAKE_CYCLES(CYC), .PWRUP_CYCLES(CYC)) adc_lp_host_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.host));
    adc_lp_device #(.CONV_CYCLES(CYC), .WAKE_CYCLES(CYC), .PWRUP_CYCLES(CYC)) adc_lp_device_inst (
        .pclk(pclk), .presetn(presetn), .link(link.device), .analog_power_on(analog_power_on),
        .blocks_reduced_power(blocks_reduced_power), .in_light_sleep(in_light_sleep),
        .in_deep_sleep(in_deep_sleep), .conversion_done(conv_done), .light_sleep_enable(light_sleep_enable),
        .deep_sleep_request(deep_sleep_request));
    adc_lp_device #(.CONV_CYCLES(CYC), .WAKE_CYCLES(CYC), .PWRUP_CYCLES(CYC)) adc_lp_device_inst2 (
        .pclk(pclk), .presetn(presetn), .link(bad_link.device), .analog_power_on(),
        .blocks_reduced_power(), .in_light_sleep(), .in_deep_sleep(), .conversion_done(),
        .light_sleep_enable(b_ls_en), .deep_sleep_request(b_ds_req));
    adc_lp_monitor adc_lp_monitor_inst (.pclk(pclk), .presetn(presetn),
        .convert_start_select(link.convert_start_select), .ready_indicator(link.ready_indicator),
        .reg_wr_strobe(link.reg_wr_strobe), .reg_wr_addr(link.reg_wr_addr), .reg_wr_data(link.reg_wr_data),
        .analog_power_on(analog_power_on), .blocks_reduced_power(blocks_reduced_power),
        .in_light_sleep(in_light_sleep), .in_deep_sleep(in_deep_sleep),
        .light_sleep_enable(light_sleep_enable), .deep_sleep_request(deep_sleep_request));
    initial begin
        forever #(lp_pkg::CLK_NS / 2) pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (conv_done === 1'b1) begin
            done_seen <= done_seen + 1;
        end
    end
    function automatic logic exp_ls(input logic [1:0] cfg);
        return cfg[0] & cfg[1];
    endfunction
    function automatic logic [31:0] exp_status(input logic pin, input logic ls, input logic ds);
        return {27'h0, ds, ls, pin, 1'b1, 1'b0};
    endfunction
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    // entered just after a rising edge; the trailing edge keeps psel from being driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            $display("FAIL %0t pready never came", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic run_op(input logic [2:0] op);
        logic [31:0] s;
        logic e;
        int n;
        int d;
        d = done_seen;
        wr(lp_pkg::CMD_OFS, {29'h0, op});
        n = 0;
        do begin
            apb(1'b0, lp_pkg::STATUS_OFS, 32'h0, s, e);
            n++;
        end while (s[0] !== 1'b0 && n < 500);
        if (s[0] !== 1'b0) begin
            err_total++;
            $display("FAIL %0t busy did not clear", $time);
        end
        repeat (2) @(posedge pclk);
        if (op == lp_pkg::OP_CONVERT) begin
            check_word(32'(done_seen - d), 32'h1);
        end
    endtask
    task automatic bad_wr(input logic [7:0] a, input logic [7:0] d);
        bad_link.reg_wr_strobe <= 1'b1;
        bad_link.reg_wr_addr <= a;
        bad_link.reg_wr_data <= d;
        @(posedge pclk);
        bad_link.reg_wr_strobe <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #(lp_pkg::CLK_NS * 20000);
        err_total++;
        $display("FAIL %0t watchdog expired", $time);
        give_verdict();
    end
    initial begin
        logic [31:0] r, v;
        logic e;
        bad_link.convert_start_select = 1'b0;
        bad_link.reg_wr_strobe = 1'b0;
        bad_link.reg_wr_addr = 8'h00;
        bad_link.reg_wr_data = 8'h00;
        v = 32'h0;
        void'($urandom(32'hd728));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, lp_pkg::CFG_OFS, 32'h0, r, e);
        check_word(r, {30'h0, lp_pkg::CFG_RESET});
        apb(1'b0, lp_pkg::STATUS_OFS, 32'h0, r, e);
        check_word(r & 32'h1f, exp_status(1'b0, 1'b0, 1'b0));
        apb(1'b0, 8'h0c, 32'h0, r, e);
        check_bit(e, 1'b1);
        check_word(r, 32'h0);
        // codes outside the command set must leave the link idle
        for (int i = 0; i < 3; i++) begin
            wr(lp_pkg::CMD_OFS, (i == 0) ? 32'h0 : 32'(5 + i));
            apb(1'b0, lp_pkg::STATUS_OFS, 32'h0, r, e);
            check_word(r & 32'h1f, exp_status(1'b0, 1'b0, 1'b0));
        end
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'h7 : $urandom();
            wr(lp_pkg::CFG_OFS, v);
            apb(1'b0, lp_pkg::CFG_OFS, 32'h0, r, e);
            check_word(r, {30'h0, v[1:0]});
            run_op(lp_pkg::OP_CONFIG_LS);
            check_bit(light_sleep_enable, v[0]);
            run_op(lp_pkg::OP_CONVERT);
            check_bit(in_light_sleep, exp_ls(v[1:0]));
            check_bit(blocks_reduced_power, exp_ls(v[1:0]));
            check_bit(analog_power_on, 1'b1);
            if (v[1]) begin
                if (v[2]) begin
                    // convert with the pin still high: the host drops it, waits, then raises it
                    run_op(lp_pkg::OP_CONVERT);
                    check_bit(in_light_sleep, exp_ls(v[1:0]));
                end
                run_op(lp_pkg::OP_WAKE);
                check_bit(in_light_sleep, 1'b0);
            end
        end
        run_op(lp_pkg::OP_DS_ENTER);
        check_bit(in_deep_sleep, 1'b1);
        check_bit(analog_power_on, 1'b0);
        check_bit(link.ready_indicator, 1'b1);
        apb(1'b0, lp_pkg::STATUS_OFS, 32'h0, r, e);
        check_word(r & 32'h1f, exp_status(1'b0, v[0], 1'b1));
        apb(1'b0, lp_pkg::CFG_OFS, 32'h0, r, e);
        check_word(r, {30'h0, v[1:0]});
        run_op(lp_pkg::OP_DS_EXIT);
        check_bit(deep_sleep_request, 1'b0);
        check_bit(link.ready_indicator, 1'b1);
        check_bit(in_deep_sleep, 1'b0);
        run_op(lp_pkg::OP_CONVERT);
        check_bit(analog_power_on, 1'b1);
        bad_wr(lp_pkg::PWRCTL_ADDR, 8'h03);
        check_bit(b_ls_en, 1'b0);
        check_bit(b_ds_req, 1'b0);
        bad_wr(lp_pkg::KEY_ADDR, lp_pkg::KEY_VALUE);
        bad_wr(lp_pkg::PWRCTL_ADDR, 8'h01);
        check_bit(b_ls_en, 1'b1);
        bad_wr(lp_pkg::KEY_ADDR, lp_pkg::KEY_VALUE);
        bad_wr(8'h06, 8'h00);
        bad_wr(lp_pkg::PWRCTL_ADDR, 8'h02);
        check_bit(b_ls_en, 1'b1);
        check_bit(b_ds_req, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
